// *** rtl/urx_pkg.sv ***
// Package: register map, field positions and shared types of the receive status and baud block
package urx_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_BAUD_HIGH = 8'h14;
    localparam logic [7:0] ADDR_BAUD_MIDDLE = 8'h18;
    localparam logic [7:0] ADDR_BAUD_LOW = 8'h1c;
    localparam logic [7:0] ADDR_CONTROL = 8'h20;
    localparam logic [7:0] ADDR_BAUD_RESET = 8'h00;

    // ------------------------------------------------------------------
    // Status bit positions
    // ------------------------------------------------------------------
    localparam int BIT_BREAK = 1;
    localparam int BIT_RESUME = 2;
    localparam int BIT_PARITY = 3;
    localparam int BIT_OVERRUN = 4;
    localparam int BIT_FRAMING = 5;

    // ------------------------------------------------------------------
    // Control bit positions
    // ------------------------------------------------------------------
    localparam int CTL_SOFT_RESET_N = 0;
    localparam int CTL_ERR_IRQ_EN = 1;
    localparam int CTL_BRK_IRQ_EN = 2;
    localparam int CTL_RES_IRQ_EN = 3;
    localparam int CTL_INT_CLOCK = 4;
    localparam int CTL_CLKPIN_FUNC = 5;
    localparam int CTL_CLKPIN_DIR = 6;
    localparam int CTL_ISO_MODE = 7;
    localparam int CTL_PARITY_EN = 8;
    localparam int CTL_ADDR_MODE = 9;
    localparam int CTL_ODD_PARITY = 10;
    localparam logic [10:0] CTL_RESET = 11'h000;

    // ------------------------------------------------------------------
    // Timing and bus response codes
    // ------------------------------------------------------------------
    localparam logic [3:0] BREAK_BITS = 4'ha;
    localparam logic [23:0] ASYNC_ZERO_DIV = 24'h00000f;
    localparam logic [23:0] ISO_ZERO_DIV = 24'h000001;
    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;

    // Character delivered by the receiver when a frame is moved into the buffer
    typedef struct packed {
        logic [7:0] data;
        logic addr_bit;
        logic parity_bit;
        logic stop_ok;
    } urx_char_t;

    typedef enum logic [1:0] {
        URX_BRK_IDLE = 2'b00,
        URX_BRK_COUNT = 2'b01,
        URX_BRK_DONE = 2'b11
    } urx_brk_state_t;

endpackage

// *** rtl/urx_status_baud.sv ***
// Receive error flags, their interrupt gating, and the 24-bit baud generator
//
// Contract
// - framing error sets on missing first stop
// - framing error interrupts, write-one clears
// - overrun sets on unread buffer overwrite
// - overrun interrupts, write-one clears
// - parity error; address bit counted in address mode
// - parity disabled keeps parity flag zero
// - parity error interrupts, write-one clears
// - resume flag sets on wake activity
// - resume flag write-one clears, zero ignored
// - break after ten low bits following framing
// - break interrupt gated by break enable
// - any-error bit ORs five flags
// - any-error clears only with five flags
// - status bit six reads zero
// - three divisor bytes form 24-bit divisor
// - async rate clock over 8(div+1), zero sixteen
// - iso rate clock over div+1, zero two; an even div gives div+2
// - sample falling, launch rising serial edge
// - internal clock driven when function and direction
// - external clock taken from pin, max clock/8
// - flags update on each buffer transfer
// - soft reset holds flags at zero
module urx_status_baud
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire urx_pkg::urx_char_t rx_char,
    input wire logic rx_char_valid,
    input wire logic rx_buffer_read,
    input wire logic rx_pin,
    input wire logic wake_activity,
    input wire logic serial_clock_pin_in,
    output logic serial_clock_pin_out,
    output logic serial_clock_pin_oe,
    output logic rx_sample_tick,
    output logic tx_launch_tick,
    output logic bit_tick,
    output logic soft_reset_n,
    output logic error_irq
);

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [7:0] baud_divisor_high;
    logic [7:0] baud_divisor_middle;
    logic [7:0] baud_divisor_low;
    logic [10:0] control;
    logic framing_error_flag;
    logic overrun_flag;
    logic parity_error_flag;
    logic resume_event_flag;
    logic break_detect_flag;
    logic any_receive_error_flag;
    logic rx_buffer_full;

    logic [7:0] aw_addr;
    logic aw_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic w_held;
    logic wr_go;
    logic [6:0] w1c;

    assign wr_go = aw_held && w_held && !s_axi_bvalid;

    // ------------------------------------------------------------------
    // AXI4-Lite write path
    // ------------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= urx_pkg::AXI_OKAY;
        end
        else
        begin
            s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_go)
            begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                case (aw_addr)
                    urx_pkg::ADDR_STATUS, urx_pkg::ADDR_BAUD_HIGH, urx_pkg::ADDR_BAUD_MIDDLE,
                    urx_pkg::ADDR_BAUD_LOW, urx_pkg::ADDR_CONTROL:
                        s_axi_bresp <= urx_pkg::AXI_OKAY;
                    default:
                        s_axi_bresp <= urx_pkg::AXI_SLVERR;
                endcase
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // Write-one-to-clear mask for the status byte
    assign w1c = (wr_go && aw_addr == urx_pkg::ADDR_STATUS && w_strb[0]) ? w_data[6:0] : 7'h00;

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            baud_divisor_high <= urx_pkg::ADDR_BAUD_RESET;
            baud_divisor_middle <= urx_pkg::ADDR_BAUD_RESET;
            baud_divisor_low <= urx_pkg::ADDR_BAUD_RESET;
            control <= urx_pkg::CTL_RESET;
        end
        else if (wr_go)
        begin
            if (aw_addr == urx_pkg::ADDR_BAUD_HIGH && w_strb[0])
                baud_divisor_high <= w_data[7:0];
            if (aw_addr == urx_pkg::ADDR_BAUD_MIDDLE && w_strb[0])
                baud_divisor_middle <= w_data[7:0];
            if (aw_addr == urx_pkg::ADDR_BAUD_LOW && w_strb[0])
                baud_divisor_low <= w_data[7:0];
            if (aw_addr == urx_pkg::ADDR_CONTROL)
            begin
                if (w_strb[0])
                    control[7:0] <= w_data[7:0];
                if (w_strb[1])
                    control[10:8] <= w_data[10:8];
            end
        end
    end

    always_ff @(posedge aclk)
        soft_reset_n <= aresetn && control[urx_pkg::CTL_SOFT_RESET_N];

    // ------------------------------------------------------------------
    // Receive status flags
    // ------------------------------------------------------------------
    logic flags_hold;
    logic char_take;
    logic parity_calc;
    logic parity_bad;
    logic break_set;

    assign flags_hold = !control[urx_pkg::CTL_SOFT_RESET_N];
    // updates only on a buffer transfer
    assign char_take = rx_char_valid && !flags_hold;
    // address bit joins parity in address mode
    assign parity_calc = (^rx_char.data)
        ^ (control[urx_pkg::CTL_ADDR_MODE] & rx_char.addr_bit)
        ^ control[urx_pkg::CTL_ODD_PARITY];
    assign parity_bad = parity_calc != rx_char.parity_bit;

    // Buffer occupancy tracks whether software has read the last character
    always_ff @(posedge aclk)
    begin
        if (!aresetn || flags_hold)
        begin
            rx_buffer_full <= 1'b0;
        end
        else if (char_take)
        begin
            rx_buffer_full <= 1'b1;
        end
        else if (rx_buffer_read)
        begin
            rx_buffer_full <= 1'b0;
        end
    end

    // Set wins over a same-cycle write-one clear in every flag below
    always_ff @(posedge aclk)
    begin
        // frozen at zero under soft reset
        if (!aresetn || flags_hold)
        begin
            framing_error_flag <= 1'b0;
            overrun_flag <= 1'b0;
            parity_error_flag <= 1'b0;
            resume_event_flag <= 1'b0;
            break_detect_flag <= 1'b0;
        end
        else
        begin
            // only the first stop bit is checked
            if (char_take && !rx_char.stop_ok)
                framing_error_flag <= 1'b1;
            else if (w1c[urx_pkg::BIT_FRAMING])
                framing_error_flag <= 1'b0;
            if (char_take && rx_buffer_full && !rx_buffer_read)
                overrun_flag <= 1'b1;
            else if (w1c[urx_pkg::BIT_OVERRUN])
                overrun_flag <= 1'b0;
            // disabled parity never sets, and reads zero
            if (char_take && control[urx_pkg::CTL_PARITY_EN] && parity_bad)
                parity_error_flag <= 1'b1;
            else if (w1c[urx_pkg::BIT_PARITY] || !control[urx_pkg::CTL_PARITY_EN])
                parity_error_flag <= 1'b0;
            if (wake_activity)
                resume_event_flag <= 1'b1;
            else if (w1c[urx_pkg::BIT_RESUME])
                resume_event_flag <= 1'b0;
            if (break_set)
                break_detect_flag <= 1'b1;
            else if (w1c[urx_pkg::BIT_BREAK])
                break_detect_flag <= 1'b0;
        end
    end

    // OR of the five flags, registered alongside them
    // falls only once all five are clear
    always_ff @(posedge aclk)
    begin
        if (!aresetn || flags_hold)
        begin
            any_receive_error_flag <= 1'b0;
        end
        else
        begin
            any_receive_error_flag <= (char_take && !rx_char.stop_ok)
                || (char_take && rx_buffer_full && !rx_buffer_read)
                || (char_take && control[urx_pkg::CTL_PARITY_EN] && parity_bad)
                || wake_activity || break_set
                || (framing_error_flag && !w1c[urx_pkg::BIT_FRAMING])
                || (overrun_flag && !w1c[urx_pkg::BIT_OVERRUN])
                || (parity_error_flag && !w1c[urx_pkg::BIT_PARITY]
                    && control[urx_pkg::CTL_PARITY_EN])
                || (resume_event_flag && !w1c[urx_pkg::BIT_RESUME])
                || (break_detect_flag && !w1c[urx_pkg::BIT_BREAK]);
        end
    end

    // ------------------------------------------------------------------
    // Break detector
    // ------------------------------------------------------------------
    urx_pkg::urx_brk_state_t brk_state;
    logic [3:0] brk_bits;

    assign break_set = (brk_state == urx_pkg::URX_BRK_COUNT) && bit_tick && !rx_pin
        && (brk_bits == urx_pkg::BREAK_BITS - 4'h1);

    // ten bit times low after a framing error
    always_ff @(posedge aclk)
    begin
        if (!aresetn || flags_hold)
        begin
            brk_state <= urx_pkg::URX_BRK_IDLE;
            brk_bits <= 4'h0;
        end
        else
        begin
            unique case (brk_state)
                urx_pkg::URX_BRK_IDLE:
                begin
                    brk_bits <= 4'h0;
                    if (char_take && !rx_char.stop_ok)
                        brk_state <= urx_pkg::URX_BRK_COUNT;
                end
                urx_pkg::URX_BRK_COUNT:
                begin
                    if (rx_pin)
                        brk_state <= urx_pkg::URX_BRK_IDLE;
                    else if (break_set)
                        brk_state <= urx_pkg::URX_BRK_DONE;
                    else if (bit_tick)
                        brk_bits <= brk_bits + 4'h1;
                end
                urx_pkg::URX_BRK_DONE:
                begin
                    // One break per low period; rearms when the line returns high
                    if (rx_pin)
                        brk_state <= urx_pkg::URX_BRK_IDLE;
                end
                default:
                    brk_state <= urx_pkg::URX_BRK_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Baud generator
    // ------------------------------------------------------------------
    logic [23:0] divisor;
    logic [23:0] reload;
    logic [23:0] baud_count;
    logic [2:0] async_phase;
    logic phase_end;
    logic int_clk;
    logic ext_clk_q;
    logic ext_clk_prev;
    logic serial_clk;
    logic serial_clk_prev;
    logic internal_sel;

    assign divisor = {baud_divisor_high, baud_divisor_middle, baud_divisor_low};
    assign internal_sel = control[urx_pkg::CTL_INT_CLOCK];
    // async half-period 4(div+1), zero gives sixteen overall
    // iso half-period is div/2+1 clocks with div/2 rounded down, zero gives two
    always_comb
    begin
        if (control[urx_pkg::CTL_ISO_MODE])
            reload = (divisor == 24'h000000) ? urx_pkg::ISO_ZERO_DIV - 24'h000001
                                             : {1'b0, divisor[23:1]};
        else
            reload = (divisor == 24'h000000) ? urx_pkg::ASYNC_ZERO_DIV >> 1 : divisor;
    end
    assign phase_end = (baud_count == 24'h000000)
        && (control[urx_pkg::CTL_ISO_MODE] || async_phase == 3'h3
            || divisor == 24'h000000);

    always_ff @(posedge aclk)
    begin
        if (!aresetn || flags_hold || !internal_sel)
        begin
            baud_count <= 24'h000000;
            async_phase <= 3'h0;
            int_clk <= 1'b1;
        end
        else if (baud_count == 24'h000000)
        begin
            baud_count <= reload;
            async_phase <= phase_end ? 3'h0 : async_phase + 3'h1;
            if (phase_end)
                int_clk <= !int_clk;
        end
        else
        begin
            baud_count <= baud_count - 24'h000001;
        end
    end

    // external clock sampled from the pin
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ext_clk_q <= 1'b1;
            ext_clk_prev <= 1'b1;
            serial_clk_prev <= 1'b1;
        end
        else
        begin
            ext_clk_q <= serial_clock_pin_in;
            ext_clk_prev <= ext_clk_q;
            serial_clk_prev <= serial_clk;
        end
    end
    assign serial_clk = internal_sel ? int_clk : ext_clk_prev;

    // sample on falling, launch on rising
    always_ff @(posedge aclk)
    begin
        rx_sample_tick <= aresetn && serial_clk_prev && !serial_clk;
        tx_launch_tick <= aresetn && !serial_clk_prev && serial_clk;
        bit_tick <= aresetn && serial_clk_prev && !serial_clk;
    end

    // pin driven only with function and direction set
    always_ff @(posedge aclk)
    begin
        serial_clock_pin_out <= aresetn && int_clk;
        serial_clock_pin_oe <= aresetn && internal_sel && control[urx_pkg::CTL_CLKPIN_FUNC]
            && control[urx_pkg::CTL_CLKPIN_DIR];
    end

    // framing, overrun, parity gated by error enable
    // break by its own enable, resume by its own
    always_ff @(posedge aclk)
        error_irq <= aresetn && ((control[urx_pkg::CTL_ERR_IRQ_EN]
                && (framing_error_flag || overrun_flag || parity_error_flag))
            || (control[urx_pkg::CTL_BRK_IRQ_EN] && break_detect_flag)
            || (control[urx_pkg::CTL_RES_IRQ_EN] && resume_event_flag));

    // ------------------------------------------------------------------
    // AXI4-Lite read path
    // ------------------------------------------------------------------
    logic [31:0] rd_word;
    logic rd_ok;

    always_comb
    begin
        rd_word = 32'h00000000;
        rd_ok = 1'b1;
        case (s_axi_araddr)
            // bit six and upper bits read zero
            urx_pkg::ADDR_STATUS:
                rd_word = {25'h0000000, 1'b0, framing_error_flag, overrun_flag,
                           parity_error_flag, resume_event_flag, break_detect_flag,
                           any_receive_error_flag};
            urx_pkg::ADDR_BAUD_HIGH:
                rd_word = {24'h000000, baud_divisor_high};
            urx_pkg::ADDR_BAUD_MIDDLE:
                rd_word = {24'h000000, baud_divisor_middle};
            urx_pkg::ADDR_BAUD_LOW:
                rd_word = {24'h000000, baud_divisor_low};
            urx_pkg::ADDR_CONTROL:
                rd_word = {21'h000000, control};
            default:
                rd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= urx_pkg::AXI_OKAY;
        end
        else
        begin
            s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_ok ? urx_pkg::AXI_OKAY : urx_pkg::AXI_SLVERR;
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

endmodule

// *** dv/urx_props.sv ***
// Checker: port-level properties of the receive status and baud block
module urx_props
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic rx_sample_tick,
    input wire logic tx_launch_tick,
    input wire logic bit_tick,
    input wire logic soft_reset_n,
    input wire logic error_irq
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    hard_reset_a: assert property (disable iff (1'h0) !aresetn |=>
        !error_irq && !soft_reset_n && !s_axi_bvalid && !s_axi_rvalid) else $error("reset");
    soft_hold_a: assert property (!soft_reset_n [*4] |-> !error_irq)
        else $error("irq under soft reset");
    ticks_equal_a: assert property (bit_tick == rx_sample_tick)
        else $error("bit tick");
    edges_apart_a: assert property (rx_sample_tick |-> !tx_launch_tick)
        else $error("edge overlap");
    tick_gap_a: assert property (rx_sample_tick |=> !rx_sample_tick)
        else $error("tick gap");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |-> ##1 s_axi_rvalid)
        else $error("read answer");
    r_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("rvalid held");
    b_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("bvalid held");
    cover property ($rose(error_irq));
    cover property (rx_sample_tick);
    cover property ($rose(soft_reset_n));
endmodule

// *** dv/urx_peer.sv ***
// Serial peer model: delivers characters, drives the line and the pin clock
module urx_peer
(
    input wire logic aclk,
    input wire logic bit_tick,
    output urx_pkg::urx_char_t rx_char,
    output logic rx_char_valid,
    output logic rx_pin,
    output logic wake_activity,
    output logic serial_clock_pin_in
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        rx_char = '0;
        rx_char_valid = 1'h0;
        rx_pin = 1'h1;
        wake_activity = 1'h0;
        serial_clock_pin_in = 1'h1;
    end
    task automatic send(input logic [7:0] d, input logic a, p, s);
        @(posedge aclk);
        rx_char <= '{d, a, p, s};
        rx_char_valid <= 1'h1;
        @(posedge aclk);
        // Stale character is inverted so nothing can latch it late
        rx_char <= ~rx_char;
        rx_char_valid <= 1'h0;
    endtask
    task automatic brk(input int n);
        int k;
        int g;
        k = 0;
        g = 0;
        // Line is already low when the cut frame lands
        rx_pin <= 1'h0;
        send(8'h00, 1'h0, 1'h0, 1'h0);
        while (k < n && g < 2000)
        begin
            @(posedge aclk);
            g++;
            k += int'(bit_tick);
        end
        rx_pin <= 1'h1;
    endtask
    task automatic wake;
        @(posedge aclk);
        wake_activity <= 1'h1;
        @(posedge aclk);
        wake_activity <= 1'h0;
    endtask
    task automatic eclk(input int n);
        repeat (n)
        begin
            repeat (8) @(posedge aclk);
            serial_clock_pin_in <= ~serial_clock_pin_in;
        end
    endtask
endmodule

// *** dv/test_uart_rx_error_flags_baud_gen.sv ***
// Testbench: register bus scenarios for the receive status and baud block
module test_uart_rx_error_flags_baud_gen;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] ST = urx_pkg::ADDR_STATUS;
    localparam logic [7:0] CT = urx_pkg::ADDR_CONTROL;
    localparam logic [7:0] BH = urx_pkg::ADDR_BAUD_HIGH;
    logic aclk = 1'h0, aresetn = 1'h0, rx_buffer_read = 1'h0;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    urx_pkg::urx_char_t rx_char;
    logic rx_char_valid, rx_pin, wake_activity, serial_clock_pin_in, serial_clock_pin_out;
    logic serial_clock_pin_oe, rx_sample_tick, tx_launch_tick, bit_tick, soft_reset_n, error_irq;
    int num_errors = 0, checked = 0, ticks = 0;
    logic [31:0] pct [4] = '{32'h31f, 32'h11f, 32'h1f, 32'h51f};
    logic [31:0] pex [4] = '{32'h0, 32'h9, 32'h0, 32'h0};
    logic [31:0] bct [4] = '{32'h71, 32'h71, 32'hf1, 32'hf1};
    int bdv [4] = '{0, 2, 0, 3};
    int bpe [4] = '{16, 24, 2, 4};
    urx_status_baud i_dut (.*);
    urx_peer i_peer (.*);
    always #50 aclk = ~aclk;
    always @(posedge aclk) ticks <= ticks + int'(rx_sample_tick);
    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic tally_and_finish;
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, e);
        checked++;
        if (s !== e)
        begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic tmo(input int n);
        if (n >= 60)
        begin
            num_errors++;
            tally_and_finish;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do
        begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid && n < 60);
        s_axi_bready <= 1'h0;
        tmo(n);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do
        begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid && n < 60);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
        tmo(n);
    endtask
    task automatic rs(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk(d, e);
    endtask
    task automatic bufrd;
        @(posedge aclk);
        rx_buffer_read <= 1'h1;
        @(posedge aclk);
        rx_buffer_read <= 1'h0;
    endtask
    // Aligns on one tick, then counts cycles to the next
    task automatic per(output int p);
        repeat (2)
        begin
            p = 0;
            do
            begin
                @(posedge aclk);
                p++;
            end while (!rx_sample_tick && p < 900);
        end
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    initial
    begin
        logic [31:0] d;
        logic [1:0] r;
        int p;
        int t0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'h1;
        for (logic [7:0] a = BH; a <= 8'h1c; a += 8'h4)
        begin
            rs(a, 32'h0);
            wr(a, 32'(a));
            rs(a, 32'(a));
            wr(a, 32'h0);
        end
        rd(8'h3c, d, r);
        chk(32'(r), 32'(urx_pkg::AXI_SLVERR));
        wr(CT, 32'h1f);
        i_peer.send(8'h00, 1'h0, 1'h0, 1'h0);
        rs(ST, 32'h21);
        chk(32'(error_irq), 32'h1);
        wr(ST, 32'h0);
        rs(ST, 32'h21);
        i_peer.send(8'h00, 1'h0, 1'h0, 1'h1);
        wr(ST, 32'h20);
        rs(ST, 32'h11);
        wr(ST, 32'h10);
        bufrd;
        i_peer.send(8'h00, 1'h0, 1'h0, 1'h1);
        rs(ST, 32'h0);
        chk(32'(error_irq), 32'h0);
        for (int i = 0; i < 4; i++)
        begin
            bufrd;
            wr(CT, pct[i]);
            i_peer.send(8'h01, 1'h1, 1'h0, 1'h1);
            rs(ST, pex[i]);
            wr(ST, 32'h3e);
        end
        i_peer.wake;
        rs(ST, 32'h05);
        wr(ST, 32'h04);
        rs(ST, 32'h0);
        wr(CT, 32'h1f);
        bufrd;
        i_peer.brk(11);
        rs(ST, 32'h23);
        wr(ST, 32'h20);
        rs(ST, 32'h03);
        chk(32'(error_irq), 32'h1);
        wr(CT, 32'h1b);
        repeat (3) @(posedge aclk);
        chk(32'(error_irq), 32'h0);
        wr(ST, 32'h7f);
        rs(ST, 32'h0);
        i_peer.wake;
        wr(CT, 32'h0);
        i_peer.wake;
        rs(ST, 32'h0);
        for (int i = 0; i < 4; i++)
        begin
            wr(CT, 32'h0);
            wr(BH + 8'h08, 32'(bdv[i]));
            wr(CT, bct[i]);
            per(p);
            chk(p, bpe[i]);
        end
        chk(32'(serial_clock_pin_oe), 32'h1);
        wr(CT, 32'h31);
        repeat (2) @(posedge aclk);
        chk(32'(serial_clock_pin_oe), 32'h0);
        wr(CT, 32'h21);
        t0 = ticks;
        i_peer.eclk(8);
        repeat (6) @(posedge aclk);
        chk(ticks - t0, 4);
        tally_and_finish;
    end
endmodule
bind urx_status_baud urx_props i_props (.*);
